/* src/dcv_pkg.sv */
// Package: object indices, word bit positions, reset values and states
package dcv_pkg;

	// Object indices of the drive's dictionary
	localparam logic [15:0] IDX_COMMAND  = 16'h6040;
	localparam logic [15:0] IDX_STATE    = 16'h6041;
	localparam logic [15:0] IDX_TARGET   = 16'h6042;
	localparam logic [15:0] IDX_DEMAND   = 16'h6043;
	localparam logic [15:0] IDX_ACTUAL   = 16'h6044;
	localparam logic [15:0] IDX_LIMITS   = 16'h6046;
	localparam logic [15:0] IDX_ACCEL    = 16'h6048;
	localparam logic [7:0]  SUB_ZERO     = 8'h00;
	localparam logic [7:0]  SUB_ONE      = 8'h01;
	localparam logic [7:0]  SUB_TWO      = 8'h02;
	localparam logic [7:0]  LIMITS_COUNT = 8'h02;

	// Command word bits
	localparam int CMD_SWITCH_ON = 0;
	localparam int CMD_POWER     = 1;
	localparam int CMD_QHALT_N   = 2;
	localparam int CMD_RUN       = 3;
	localparam int CMD_MODE_LO   = 4;
	localparam int CMD_MODE_HI   = 6;
	localparam int CMD_FCLEAR    = 7;
	localparam int CMD_HALT      = 8;
	localparam int CMD_MODE_B9   = 9;

	// Status word bits
	localparam int ST_READY     = 0;
	localparam int ST_SWON      = 1;
	localparam int ST_OPEN      = 2;
	localparam int ST_FAULT     = 3;
	localparam int ST_POWER     = 4;
	localparam int ST_QHALT_N   = 5;
	localparam int ST_LOCKED    = 6;
	localparam int ST_WARN      = 7;
	localparam int ST_SYNC      = 8;
	localparam int ST_HOST      = 9;
	localparam int ST_GOAL      = 10;
	localparam int ST_LIMIT     = 11;
	localparam int ST_MODE_LO   = 12;
	localparam int ST_MODE_HI   = 13;
	localparam int ST_CLOSED    = 15;

	// Reset values
	localparam logic [15:0] RST_COMMAND = 16'h0000;
	localparam logic [15:0] RST_STATE   = 16'h0000;
	localparam logic [15:0] RST_TARGET  = 16'h00c8;
	localparam logic [15:0] RST_SPEED   = 16'h0000;
	localparam logic [31:0] RST_FLOOR   = 32'h0000_0000;
	localparam logic [31:0] RST_CEIL    = 32'h0000_7530;
	localparam logic [31:0] RST_DSPEED  = 32'h0000_01f4;
	localparam logic [15:0] RST_DTIME   = 16'h0001;

	// Operating modes, as selected by the master
	localparam logic [7:0] MODE_PROF_POS = 8'h01;
	localparam logic [7:0] MODE_VELOCITY = 8'h02;
	localparam logic [7:0] MODE_PROF_VEL = 8'h03;
	localparam logic [7:0] MODE_PROF_TRQ = 8'h04;
	localparam logic [7:0] MODE_INTERP   = 8'h07;

	// Power state machine
	typedef enum logic [2:0] {
		DCV_NOT_READY = 3'b000,
		DCV_LOCKED    = 3'b001,
		DCV_READY     = 3'b010,
		DCV_SWON      = 3'b011,
		DCV_OPEN      = 3'b100,
		DCV_QHALT     = 3'b101,
		DCV_FREACT    = 3'b110,
		DCV_FAULT     = 3'b111
	} dcv_state_e;

	// Master access answer codes
	localparam logic [1:0] ACK_OK      = 2'h0;
	localparam logic [1:0] ACK_NOOBJ   = 2'h1;
	localparam logic [1:0] ACK_RDONLY  = 2'h2;

endpackage : dcv_pkg

/* src/dcv_if.sv */
// Interface: object access between fieldbus master and drive
`timescale 1ns/100ps
interface dcv_if;
	logic        req;
	logic        wr;
	logic [15:0] index;
	logic [7:0]  subindex;
	logic [31:0] wdata;
	logic        ack;
	logic [1:0]  ack_code;
	logic [31:0] rdata;

	modport drive (
		input  req,
		input  wr,
		input  index,
		input  subindex,
		input  wdata,
		output ack,
		output ack_code,
		output rdata
	);

	modport master (
		output req,
		output wr,
		output index,
		output subindex,
		output wdata,
		input  ack,
		input  ack_code,
		input  rdata
	);
endinterface : dcv_if

/* src/dcv_drive.sv */
// Drive end: command word, power state machine, status word, velocity ramp
//
// How it works
// - Command bit 0 requests switched on
// - Command bit 1 requests voltage enabled
// - Command bit 2 low requests quick stop
// - Command bit 3 requests operation enabled
// - Command bit 7 clears fault or warning
// - Bit 8 halts in five listed modes
// - Bits 4-6 and 9 are mode specific
// - Status bits 0-2 show ready, on, enabled
// - Status bit 3 fault, bit 7 warning
// - Bit 4 voltage, bit 5 quick, bit 6 locked
// - Status bit 8 follows fieldbus sync
// - Status bit 9 one from the first cycle after reset
// - Bit 15 set when enabled and closed loop
// - Status bits 12-13 are mode specific
// - State encoded in status bits 0-3, 5, 6
// - Below floor uses floor, sets bit 11
// - Above ceiling uses ceiling, sets bit 11
// - Limits unsigned 32-bit, reset 0 and 7530h
// - Target speed signed 16-bit, reset 00c8h
// - Demand and actual read-only, reset zero
// - Ramp is speed change over time change
// - Command and status 16-bit, reset zero
`timescale 1ns/100ps
module dcv_drive (
	input  wire logic        clk,
	input  wire logic        rstn,
	dcv_if.drive             bus,
	input  wire logic [7:0]  op_mode,
	input  wire logic        fault_event,
	input  wire logic        warn_event,
	input  wire logic        sync_pin,
	input  wire logic        loop_closed,
	input  wire logic [15:0] speed_sense,
	input  wire logic [1:0]  mode_status,
	output logic             motor_run,
	output logic             halt_active,
	output logic [3:0]       mode_bits,
	output logic [15:0]      speed_cmd
);

	dcv_pkg::dcv_state_e state_ff;
	dcv_pkg::dcv_state_e nxt_state;
	logic [15:0] command_ff;
	logic [15:0] status_ff;
	logic [15:0] target_ff;
	logic [15:0] demand_ff;
	logic [15:0] actual_ff;
	logic [31:0] floor_ff;
	logic [31:0] ceil_ff;
	logic [31:0] dspeed_ff;
	logic [15:0] dtime_ff;
	logic [15:0] tick_ff;
	logic        fault_ff;
	logic        warn_ff;
	logic        limit_ff;
	logic        fclear_d_ff;
	logic [1:0]  sync_ff;
	logic        ack_ff;
	logic [1:0]  code_ff;
	logic [31:0] rdata_ff;
	logic [15:0] clamped;
	logic        clamp_hit;
	logic        fclear_rise;
	logic        wr_ok;

	// Signed target against unsigned limits; negative means below floor
	function automatic logic [16:0] clamp_fn(input logic [15:0] t,
		input logic [31:0] lo, input logic [31:0] hi);
		logic [31:0] tw;
		tw = {{16{t[15]}}, t};
		if (t[15] || tw < lo)
			return {1'b1, lo[15:0]};
		else if (tw > hi)
			return {1'b1, hi[15:0]};
		else
			return {1'b0, t};
	endfunction : clamp_fn

	assign {clamp_hit, clamped} = clamp_fn(target_ff, floor_ff, ceil_ff);
	assign fclear_rise = command_ff[dcv_pkg::CMD_FCLEAR] & ~fclear_d_ff;

	////////////////////////////////////////////////////////////////////////
	// Object access

	always_comb begin
		wr_ok = 1'b0;
		case (bus.index)
			dcv_pkg::IDX_COMMAND, dcv_pkg::IDX_TARGET: wr_ok = 1'b1;
			dcv_pkg::IDX_LIMITS, dcv_pkg::IDX_ACCEL: begin
				wr_ok = bus.subindex != dcv_pkg::SUB_ZERO;
			end
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			command_ff <= dcv_pkg::RST_COMMAND;
			target_ff  <= dcv_pkg::RST_TARGET;
			floor_ff   <= dcv_pkg::RST_FLOOR;
			ceil_ff    <= dcv_pkg::RST_CEIL;
			dspeed_ff  <= dcv_pkg::RST_DSPEED;
			dtime_ff   <= dcv_pkg::RST_DTIME;
		end else if (bus.req && bus.wr && wr_ok) begin
			case (bus.index)
				dcv_pkg::IDX_COMMAND: command_ff <= bus.wdata[15:0];
				dcv_pkg::IDX_TARGET: target_ff <= bus.wdata[15:0];
				dcv_pkg::IDX_LIMITS: begin
					if (bus.subindex == dcv_pkg::SUB_ONE)
						floor_ff <= bus.wdata;
					else
						ceil_ff <= bus.wdata;
				end
				dcv_pkg::IDX_ACCEL: begin
					if (bus.subindex == dcv_pkg::SUB_ONE)
						dspeed_ff <= bus.wdata;
					else
						dtime_ff <= bus.wdata[15:0];
				end
				default: command_ff <= command_ff;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_ff   <= 1'b0;
			code_ff  <= dcv_pkg::ACK_OK;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff  <= bus.req;
			code_ff <= dcv_pkg::ACK_OK;
			case (bus.index)
				dcv_pkg::IDX_COMMAND: rdata_ff <= {16'h0000, command_ff};
				dcv_pkg::IDX_STATE:   rdata_ff <= {16'h0000, status_ff};
				dcv_pkg::IDX_TARGET:  rdata_ff <= {16'h0000, target_ff};
				dcv_pkg::IDX_DEMAND:  rdata_ff <= {16'h0000, demand_ff};
				dcv_pkg::IDX_ACTUAL:  rdata_ff <= {16'h0000, actual_ff};
				dcv_pkg::IDX_LIMITS, dcv_pkg::IDX_ACCEL: begin
					if (bus.subindex == dcv_pkg::SUB_ZERO)
						rdata_ff <= {24'h000000, dcv_pkg::LIMITS_COUNT};
					else if (bus.subindex == dcv_pkg::SUB_ONE)
						rdata_ff <= (bus.index == dcv_pkg::IDX_LIMITS)
							? floor_ff : dspeed_ff;
					else
						rdata_ff <= (bus.index == dcv_pkg::IDX_LIMITS)
							? ceil_ff : {16'h0000, dtime_ff};
				end
				default: begin
					rdata_ff <= 32'h0000_0000;
					code_ff  <= dcv_pkg::ACK_NOOBJ;
				end
			endcase
			if (bus.wr && !wr_ok && bus.req &&
				(bus.index == dcv_pkg::IDX_STATE ||
				 bus.index == dcv_pkg::IDX_DEMAND ||
				 bus.index == dcv_pkg::IDX_ACTUAL ||
				 bus.index == dcv_pkg::IDX_LIMITS ||
				 bus.index == dcv_pkg::IDX_ACCEL))
				code_ff <= dcv_pkg::ACK_RDONLY;
		end
	end

	assign bus.ack      = ack_ff;
	assign bus.ack_code = code_ff;
	assign bus.rdata    = rdata_ff;

	////////////////////////////////////////////////////////////////////////
	// Power state machine

	always_comb begin
		logic sw, pw, qn, rn;
		sw = command_ff[dcv_pkg::CMD_SWITCH_ON];
		pw = command_ff[dcv_pkg::CMD_POWER];
		qn = command_ff[dcv_pkg::CMD_QHALT_N];
		rn = command_ff[dcv_pkg::CMD_RUN];
		nxt_state = state_ff;
		case (state_ff)
			dcv_pkg::DCV_NOT_READY: nxt_state = dcv_pkg::DCV_LOCKED;
			dcv_pkg::DCV_LOCKED:
				if (pw && qn) nxt_state = dcv_pkg::DCV_READY;
			dcv_pkg::DCV_READY:
				if (!pw || !qn) nxt_state = dcv_pkg::DCV_LOCKED;
				else if (sw) nxt_state = dcv_pkg::DCV_SWON;
			dcv_pkg::DCV_SWON:
				if (!pw || !qn) nxt_state = dcv_pkg::DCV_LOCKED;
				else if (!sw) nxt_state = dcv_pkg::DCV_READY;
				else if (rn) nxt_state = dcv_pkg::DCV_OPEN;
			dcv_pkg::DCV_OPEN:
				if (!pw) nxt_state = dcv_pkg::DCV_LOCKED;
				else if (!qn) nxt_state = dcv_pkg::DCV_QHALT;
				else if (!sw) nxt_state = dcv_pkg::DCV_READY;
				else if (!rn) nxt_state = dcv_pkg::DCV_SWON;
			// Leave quick stop once the motor is at rest
			dcv_pkg::DCV_QHALT:
				if (!pw) nxt_state = dcv_pkg::DCV_LOCKED;
				else if (demand_ff == dcv_pkg::RST_SPEED)
					nxt_state = dcv_pkg::DCV_LOCKED;
			dcv_pkg::DCV_FREACT: nxt_state = dcv_pkg::DCV_FAULT;
			dcv_pkg::DCV_FAULT:
				if (fclear_rise) nxt_state = dcv_pkg::DCV_LOCKED;
			default: nxt_state = dcv_pkg::DCV_NOT_READY;
		endcase
		// Enter fault reaction once, so that it can hand over to fault
		if (fault_ff && !(state_ff inside {dcv_pkg::DCV_FREACT,
			dcv_pkg::DCV_FAULT}))
			nxt_state = dcv_pkg::DCV_FREACT;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff    <= dcv_pkg::DCV_NOT_READY;
			fclear_d_ff <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			fclear_d_ff <= command_ff[dcv_pkg::CMD_FCLEAR];
		end
	end

	// Event wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fault_ff <= 1'b0;
			warn_ff  <= 1'b0;
		end else begin
			fault_ff <= fault_event | (fault_ff & ~fclear_rise);
			warn_ff  <= warn_event | (warn_ff & ~fclear_rise);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			sync_ff <= 2'b00;
		else
			sync_ff <= {sync_ff[0], sync_pin};
	end

	////////////////////////////////////////////////////////////////////////
	// Velocity ramp

	always_comb begin
		halt_active = 1'b0;
		case (op_mode)
			dcv_pkg::MODE_PROF_POS, dcv_pkg::MODE_VELOCITY,
			dcv_pkg::MODE_PROF_VEL, dcv_pkg::MODE_PROF_TRQ,
			dcv_pkg::MODE_INTERP:
				halt_active = command_ff[dcv_pkg::CMD_HALT];
			default: halt_active = 1'b0;
		endcase
	end

	// One step of delta speed every delta time cycles
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			demand_ff <= dcv_pkg::RST_SPEED;
			tick_ff   <= 16'h0000;
			limit_ff  <= 1'b0;
		end else begin
			logic [15:0] goal;
			logic signed [16:0] diff;
			goal = (state_ff == dcv_pkg::DCV_OPEN && !halt_active)
				? clamped : dcv_pkg::RST_SPEED;
			diff = $signed({goal[15], goal}) -
				$signed({demand_ff[15], demand_ff});
			limit_ff <= clamp_hit;
			if (tick_ff + 16'h0001 >= dtime_ff) begin
				tick_ff <= 16'h0000;
				if (diff > $signed({1'b0, dspeed_ff[15:0]}))
					demand_ff <= demand_ff + dspeed_ff[15:0];
				else if (-diff > $signed({1'b0, dspeed_ff[15:0]}))
					demand_ff <= demand_ff - dspeed_ff[15:0];
				else
					demand_ff <= goal;
			end else
				tick_ff <= tick_ff + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			actual_ff <= dcv_pkg::RST_SPEED;
		else
			actual_ff <= speed_sense;
	end

	////////////////////////////////////////////////////////////////////////
	// Status word

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			status_ff <= dcv_pkg::RST_STATE;
		else begin
			logic [15:0] s;
			s = 16'h0000;
			case (state_ff)
				dcv_pkg::DCV_LOCKED: s[dcv_pkg::ST_LOCKED] = 1'b1;
				dcv_pkg::DCV_READY: s[dcv_pkg::ST_QHALT_N] = 1'b1;
				dcv_pkg::DCV_SWON: begin
					s[dcv_pkg::ST_QHALT_N] = 1'b1;
					s[dcv_pkg::ST_SWON] = 1'b1;
				end
				dcv_pkg::DCV_OPEN, dcv_pkg::DCV_QHALT: begin
					s[dcv_pkg::ST_QHALT_N] = state_ff == dcv_pkg::DCV_OPEN;
					s[dcv_pkg::ST_SWON] = 1'b1;
					s[dcv_pkg::ST_OPEN] = 1'b1;
				end
				dcv_pkg::DCV_FREACT: begin
					s[dcv_pkg::ST_SWON] = 1'b1;
					s[dcv_pkg::ST_OPEN] = 1'b1;
				end
				default: s = 16'h0000;
			endcase
			s[dcv_pkg::ST_READY] = state_ff inside {dcv_pkg::DCV_READY,
				dcv_pkg::DCV_SWON, dcv_pkg::DCV_OPEN, dcv_pkg::DCV_QHALT,
				dcv_pkg::DCV_FREACT};
			s[dcv_pkg::ST_FAULT] = state_ff inside {dcv_pkg::DCV_FREACT,
				dcv_pkg::DCV_FAULT};
			s[dcv_pkg::ST_POWER] = command_ff[dcv_pkg::CMD_POWER] &&
				state_ff != dcv_pkg::DCV_NOT_READY;
			s[dcv_pkg::ST_WARN] = warn_ff;
			s[dcv_pkg::ST_SYNC] = sync_ff[1];
			s[dcv_pkg::ST_HOST] = 1'b1;
			s[dcv_pkg::ST_GOAL] = actual_ff == clamped;
			s[dcv_pkg::ST_LIMIT] = limit_ff;
			s[dcv_pkg::ST_MODE_HI:dcv_pkg::ST_MODE_LO] = mode_status;
			s[dcv_pkg::ST_CLOSED] = state_ff == dcv_pkg::DCV_OPEN &&
				loop_closed;
			status_ff <= s;
		end
	end

	assign motor_run = state_ff == dcv_pkg::DCV_OPEN ||
		state_ff == dcv_pkg::DCV_QHALT;
	assign mode_bits = {command_ff[dcv_pkg::CMD_MODE_B9],
		command_ff[dcv_pkg::CMD_MODE_HI:dcv_pkg::CMD_MODE_LO]};
	assign speed_cmd = demand_ff;

endmodule : dcv_drive

/* src/dcv_master.sv */
// Master end: issues one object read or write per user request
`timescale 1ns/100ps
module dcv_master (
	input  wire logic        clk,
	input  wire logic        rstn,
	dcv_if.master            bus,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_wr,
	input  wire logic [15:0] cmd_index,
	input  wire logic [7:0]  cmd_sub,
	input  wire logic [31:0] cmd_wdata,
	output logic             cmd_ready,
	output logic             rsp_valid,
	output logic [1:0]       rsp_code,
	output logic [31:0]      rsp_rdata
);

	typedef enum logic [0:0] {
		DCM_IDLE = 1'b0,
		DCM_WAIT = 1'b1
	} dcm_state_e;

	dcm_state_e  state_ff;
	logic        req_ff;
	logic        wr_ff;
	logic [15:0] index_ff;
	logic [7:0]  sub_ff;
	logic [31:0] wdata_ff;
	logic        rsp_valid_ff;
	logic [1:0]  rsp_code_ff;
	logic [31:0] rsp_rdata_ff;

	// Idle takes a user request and raises req for one cycle;
	// wait holds until the drive's ack, then goes back to idle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= DCM_IDLE;
			req_ff   <= 1'b0;
			wr_ff    <= 1'b0;
			index_ff <= 16'h0000;
			sub_ff   <= 8'h00;
			wdata_ff <= 32'h0000_0000;
		end else begin
			req_ff <= 1'b0;
			case (state_ff)
				DCM_IDLE: if (cmd_valid) begin
					req_ff   <= 1'b1;
					wr_ff    <= cmd_wr;
					index_ff <= cmd_index;
					sub_ff   <= cmd_sub;
					wdata_ff <= cmd_wdata;
					state_ff <= DCM_WAIT;
				end
				DCM_WAIT: if (bus.ack) state_ff <= DCM_IDLE;
				default: state_ff <= DCM_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rsp_valid_ff <= 1'b0;
			rsp_code_ff  <= 2'h0;
			rsp_rdata_ff <= 32'h0000_0000;
		end else begin
			rsp_valid_ff <= state_ff == DCM_WAIT && bus.ack;
			if (state_ff == DCM_WAIT && bus.ack) begin
				rsp_code_ff  <= bus.ack_code;
				rsp_rdata_ff <= bus.rdata;
			end
		end
	end

	assign bus.req      = req_ff;
	assign bus.wr       = wr_ff;
	assign bus.index    = index_ff;
	assign bus.subindex = sub_ff;
	assign bus.wdata    = wdata_ff;
	assign cmd_ready    = state_ff == DCM_IDLE;
	assign rsp_valid    = rsp_valid_ff;
	assign rsp_code     = rsp_code_ff;
	assign rsp_rdata    = rsp_rdata_ff;

endmodule : dcv_master

/* sim/dcv_checker.sv */
// Checker: object bus timing and state word relations
`timescale 1ns/100ps
module dcv_checker (
	input logic        clk,
	input logic        rstn,
	input logic        req,
	input logic        wr,
	input logic [15:0] index,
	input logic [7:0]  subindex,
	input logic [31:0] wdata,
	input logic        ack,
	input logic [1:0]  ack_code,
	input logic [31:0] rdata
);
	logic        last_wr_ff;
	logic [15:0] last_idx_ff;
	logic        st_rd;
	logic        word_rd;

	////////////////////////////////////////////////////////////////////////
	function automatic logic legal_state(input logic [15:0] s);
		casez ({s[6], s[5], s[3:0]})
			6'b0?0000, 6'b1?0000, 6'b010001, 6'b010011: return 1'b1;
			6'b010111, 6'b000111, 6'b0?1111, 6'b0?1000: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : legal_state

	// Remember what the pending answer belongs to
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			last_wr_ff  <= 1'b1;
			last_idx_ff <= 16'h0000;
		end else if (req) begin
			last_wr_ff  <= wr;
			last_idx_ff <= index;
		end
	end

	assign word_rd = ack && ack_code == dcv_pkg::ACK_OK && !last_wr_ff
		&& last_idx_ff[15:3] == 13'h0c08 && last_idx_ff[2:0] <= 3'h4;
	assign st_rd = word_rd && last_idx_ff == dcv_pkg::IDX_STATE;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_ack_follows_req: assert property (req |=> ack ##1 !ack)
		else $error("answer missing or too long");
	chk_ack_has_cause: assert property (ack |-> $past(req))
		else $error("answer without request");
	chk_state_read_only: assert property (req && wr
		&& index == dcv_pkg::IDX_STATE |=> ack_code == dcv_pkg::ACK_RDONLY)
		else $error("state word write not refused");
	chk_speed_read_only: assert property (req && wr && (index ==
		dcv_pkg::IDX_DEMAND || index == dcv_pkg::IDX_ACTUAL)
		|=> ack_code == dcv_pkg::ACK_RDONLY)
		else $error("speed readback write not refused");
	chk_word_upper_zero: assert property (word_rd |-> rdata[31:16] == 0)
		else $error("16-bit object upper half not zero");
	chk_host_flag_set: assert property (st_rd |-> rdata[dcv_pkg::ST_HOST])
		else $error("host control flag low");
	chk_state_decoded: assert property (st_rd |-> legal_state(rdata[15:0]))
		else $error("state word pattern undefined");
	chk_closed_needs_run: assert property (st_rd && rdata[15]
		|-> rdata[2:0] == 3'h7 && rdata[5])
		else $error("closed loop flag outside enabled state");
	chk_locked_idle: assert property (st_rd && rdata[6]
		|-> rdata[3:0] == 4'h0)
		else $error("locked out flag with state bits set");

	cover property (st_rd && rdata[dcv_pkg::ST_LIMIT]);
	cover property (st_rd && rdata[dcv_pkg::ST_CLOSED]);
	cover property (ack && ack_code == dcv_pkg::ACK_RDONLY);
	cover property (ack && ack_code == dcv_pkg::ACK_NOOBJ);
endmodule : dcv_checker

/* sim/testbench.sv */
// Testbench: master and drive joined, driven on the master's user side
`timescale 1ns/100ps
module testbench;
	typedef struct {
		logic [15:0] ix;
		logic [1:0]  code;
		logic [31:0] data;
		logic [31:0] mask;
	} dcv_note_s;

	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  op_mode = 8'h02;
	logic        fault_event = 1'b0;
	logic        warn_event = 1'b0;
	logic        sync_pin = 1'b0;
	logic        loop_closed = 1'b1;
	logic [15:0] speed_sense = 16'h0000;
	logic [1:0]  mode_status = 2'h0;
	logic        cmd_valid = 1'b0;
	logic        cmd_wr = 1'b0;
	logic [15:0] cmd_index = 16'h0000;
	logic [7:0]  cmd_sub = 8'h00;
	logic [31:0] cmd_wdata = 32'h0000_0000;
	logic        cmd_ready;
	logic        rsp_valid;
	logic [1:0]  rsp_code;
	logic [31:0] rsp_rdata;
	logic        motor_run;
	logic        halt_active;
	logic [3:0]  mode_bits;
	logic [15:0] speed_cmd;
	logic [15:0] val;
	int          failures = 0;
	int          checked = 0;
	int          seed = 77;
	dcv_note_s   notes[$];
	dcv_note_s   n;
	logic [15:0] rix[9] = '{16'h6040, 16'h6041, 16'h6042, 16'h6043,
		16'h6044, 16'h6046, 16'h6046, 16'h6046, 16'h6048};
	logic [7:0]  rsb[9] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1,
		8'h2, 8'h1};
	logic [31:0] rval[9] = '{32'h0, 32'h0240, 32'h00c8, 32'h0, 32'h0,
		32'h2, 32'h0, 32'h7530, 32'h01f4};
	logic [15:0] scmd[3] = '{16'h0006, 16'h0007, 16'h000f};
	logic [15:0] sexp[3] = '{16'h0231, 16'h0233, 16'h8237};
	logic [7:0]  hmode[6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h06};

	dcv_if dcv_if_inst ();

	dcv_drive dcv_drive_inst (.clk(clk), .rstn(rstn), .bus(dcv_if_inst),
		.op_mode(op_mode), .fault_event(fault_event),
		.warn_event(warn_event), .sync_pin(sync_pin),
		.loop_closed(loop_closed), .speed_sense(speed_sense),
		.mode_status(mode_status), .motor_run(motor_run),
		.halt_active(halt_active), .mode_bits(mode_bits),
		.speed_cmd(speed_cmd));

	dcv_master dcv_master_inst (.clk(clk), .rstn(rstn), .bus(dcv_if_inst),
		.cmd_valid(cmd_valid), .cmd_wr(cmd_wr), .cmd_index(cmd_index),
		.cmd_sub(cmd_sub), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_code(rsp_code),
		.rsp_rdata(rsp_rdata));

	dcv_checker dcv_checker_inst (.clk(clk), .rstn(rstn),
		.req(dcv_if_inst.req), .wr(dcv_if_inst.wr),
		.index(dcv_if_inst.index), .subindex(dcv_if_inst.subindex),
		.wdata(dcv_if_inst.wdata), .ack(dcv_if_inst.ack),
		.ack_code(dcv_if_inst.ack_code), .rdata(dcv_if_inst.rdata));

	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	// Entered 1 ns after an edge; returns likewise, once answered
	task automatic acc(input logic w, input logic [15:0] ix,
			input logic [7:0] sb, input logic [31:0] d,
			input logic [1:0] ec, input logic [31:0] ed,
			input logic [31:0] m);
		notes.push_back('{ix, ec, ed, m});
		while (cmd_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		cmd_wr = w;
		cmd_index = ix;
		cmd_sub = sb;
		cmd_wdata = d;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		repeat (20) begin
			if (notes.size() == 0) break;
			@(posedge clk);
			#1;
		end
		// Missing answer counts; drop its note so later ones still pair
		if (notes.size() != 0) begin
			failures++;
			notes.delete();
		end
	endtask : acc

	task automatic wr(input logic [15:0] ix, input logic [7:0] sb,
			input logic [31:0] d);
		acc(1'b1, ix, sb, d, dcv_pkg::ACK_OK, 32'h0, 32'h0);
	endtask : wr

	task automatic st(input logic [31:0] ed, input logic [31:0] m);
		acc(1'b0, dcv_pkg::IDX_STATE, 8'h0, 32'h0, dcv_pkg::ACK_OK, ed, m);
	endtask : st

	task automatic pause(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : pause

	// Registered answer: sampled mid-cycle, away from the edge
	always @(negedge clk) begin
		if (rsp_valid === 1'b1 && notes.size() > 0) begin
			n = notes.pop_front();
			check($sformatf("code %h", n.ix), rsp_code, n.code);
			check($sformatf("data %h", n.ix), rsp_rdata & n.mask,
				n.data & n.mask);
		end
	end

	initial begin : watchdog
		#(100 * 6000);
		failures++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin : main
		pause(5);
		rstn = 1'b1;
		pause(3);
		for (int i = 0; i < 9; i++) begin
			acc(1'b0, rix[i], rsb[i], 0, 0, rval[i], '1);
		end
		$display("test reset values done");
		acc(1'b1, dcv_pkg::IDX_STATE, 8'h0, 32'h1, 2'h2, 0, 0);
		acc(1'b1, dcv_pkg::IDX_DEMAND, 8'h0, 32'h9, 2'h2, 0, 0);
		acc(1'b1, dcv_pkg::IDX_ACTUAL, 8'h0, 32'h9, 2'h2, 0, 0);
		acc(1'b1, dcv_pkg::IDX_LIMITS, 8'h0, 32'h5, 2'h2, 0, 0);
		acc(1'b0, 16'h6045, 8'h0, 32'h0, 2'h1, 0, '1);
		acc(1'b0, dcv_pkg::IDX_DEMAND, 8'h0, 0, 0, 0, '1);
		$display("test refusals done");
		for (int i = 0; i < 3; i++) begin
			wr(dcv_pkg::IDX_COMMAND, 8'h0, {16'h0, scmd[i]});
			st({16'h0, sexp[i]}, 32'h827f);
		end
		check("run", {31'h0, motor_run}, 32'h1);
		loop_closed = 1'b0;
		st(32'h0000, 32'h8000);
		loop_closed = 1'b1;
		for (int i = 0; i < 6; i++) begin
			op_mode = hmode[i];
			val = 16'h010f | (16'($random(seed)) & 16'h0270);
			wr(dcv_pkg::IDX_COMMAND, 8'h0, {16'h0, val});
			check("halt", {31'h0, halt_active}, i < 5);
			check("mode", {28'h0, mode_bits}, {val[9], val[6:4]});
		end
		op_mode = dcv_pkg::MODE_VELOCITY;
		wr(dcv_pkg::IDX_COMMAND, 8'h0, 32'h000f);
		$display("test power states done");
		sync_pin = 1'b1;
		mode_status = 2'h3;
		pause(4);
		st(32'h3300, 32'h3300);
		$display("test sync flags done");
		wr(dcv_pkg::IDX_LIMITS, 8'h2, 32'h64);
		st(32'h0800, 32'h0800);
		pause(10);
		check("ceiling", {16'h0, speed_cmd}, 32'h64);
		wr(dcv_pkg::IDX_LIMITS, 8'h1, 32'h32);
		wr(dcv_pkg::IDX_TARGET, 8'h0, 32'hfffb);
		st(32'h0800, 32'h0800);
		pause(10);
		check("floor", {16'h0, speed_cmd}, 32'h32);
		$display("test clamp done");
		wr(dcv_pkg::IDX_ACCEL, 8'h1, 32'h1);
		wr(dcv_pkg::IDX_ACCEL, 8'h2, 32'h4);
		val = 16'h0040 + (16'($random(seed)) & 16'h001f);
		wr(dcv_pkg::IDX_TARGET, 8'h0, {16'h0, val});
		acc(1'b0, dcv_pkg::IDX_TARGET, 8'h0, 0, 0, {16'h0, val}, '1);
		check("early", {31'h0, speed_cmd !== val}, 32'h1);
		pause(200);
		check("demand", {16'h0, speed_cmd}, {16'h0, val});
		speed_sense = val;
		pause(4);
		st(32'h0400, 32'h0c00);
		$display("test ramp done");
		wr(dcv_pkg::IDX_ACCEL, 8'h1, 32'h1f4);
		wr(dcv_pkg::IDX_ACCEL, 8'h2, 32'h1);
		wr(dcv_pkg::IDX_COMMAND, 8'h0, 32'h000b);
		pause(20);
		st(32'h0250, 32'h827f);
		fault_event = 1'b1;
		pause(1);
		fault_event = 1'b0;
		pause(4);
		st(32'h0008, 32'h004f);
		wr(dcv_pkg::IDX_COMMAND, 8'h0, 32'h0080);
		st(32'h0040, 32'h004f);
		warn_event = 1'b1;
		pause(1);
		warn_event = 1'b0;
		pause(3);
		st(32'h0080, 32'h0080);
		wr(dcv_pkg::IDX_COMMAND, 8'h0, 32'h0000);
		wr(dcv_pkg::IDX_COMMAND, 8'h0, 32'h0080);
		st(32'h0000, 32'h0080);
		$display("test faults done");
		print_verdict();
	end
endmodule : testbench
